/* File: prw_defs.svh */
// Offsets, field positions and reset values of the periodic reset unit.
// Assumes an APB slave with byte addresses and 32-bit data words.
`ifndef PRW_DEFS_SVH
`define PRW_DEFS_SVH

// Register byte addresses.
`define PRW_ADDR_CS1   8'h00
`define PRW_ADDR_WAKE  8'h04
`define PRW_ADDR_DIV   8'h08
`define PRW_ADDR_STS   8'h0C
`define PRW_ADDR_MASK  8'h10

// Field positions shared by both control/status registers.
`define PRW_FLAG_BIT   7
`define PRW_ACK_BIT    6
`define PRW_IVL_MSB    5

// Interrupt status and mask bit positions.
`define PRW_STS_WAKE   0
`define PRW_STS_RESET  1

// Reset values.
`define PRW_IVL_RST    6'h3F
`define PRW_DIV_RST    6'h00
`define PRW_CNT_RST    6'h00
`define PRW_STS_RST    2'h0

`endif

/* File: prw_pkg.sv */
// Types shared by the periodic reset unit and its surroundings.
// Assumes the mode code is driven by the system power controller.
package prw_pkg;

   // Processor operating mode as seen by the unit.
   typedef enum logic [2:0] {
      PM_RUN,
      PM_WAIT,
      PM_STOP4,
      PM_STOP3,
      PM_STOP2,
      PM_STOP1
   } prw_mode_e;

   // Requests to the core, interrupt and reset logic.
   typedef struct packed {
      logic clk_restart;
      logic wake_vector;
      logic sys_reset;
      logic por_exit;
      logic por_only_status;
   } prw_req_s;

   // Six-bit interval or count value.
   typedef logic [5:0] prw_ivl_t;

endpackage

/* File: prw_ctrl.sv */
// Periodic wake-up and periodic reset control with an APB register port.
// Assumes wake_tick is a one-cycle enable from the wake clock, synchronous
// to pclk, and that por_resetn is low only for a power-on reset.
`timescale 1ns/100ps
`include "prw_defs.svh"

// What this block does
// - Hardware sets reset flag; writes cannot set it.
// - Writing one to acknowledge clears reset flag.
// - Of all resets, only power-on reset clears reset flag.
// - Acknowledge reads zero; zero write ignored.
// - Reset interval counts wake-up counter periods, 1 to 63.
// - Changed interval restarts prescaler and counters.
// - Zero reset interval disables periodic reset.
// - Zero write refused when other interval zero.
// - Any reset presets reset interval to 63.
// - Wake event sets flag, requests wake vector.
// - Periodic reset requests reset, sets flag.
// - Unit's own events never reset its registers.
// - Shallow stop: restart clocks, then vector.
// - Deep stop wake exits as power-on reset.
// - Deep stop periodic reset shows power-on only.
// - Debug freeze stops every counter.
// - Wake interval counts wake clocks, preset 63.
// - Wake acknowledge clears wake flag, reads zero.
module prw_ctrl (
   // Clock and resets.
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                por_resetn,
   // APB slave.
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Time base, mode and debug.
   input  wire logic                wake_tick,
   input  wire prw_pkg::prw_mode_e  cpu_mode,
   input  wire logic                debug_freeze,
   // Requests and interrupt.
   output prw_pkg::prw_req_s        req,
   output logic                     irq
);
   import prw_pkg::*;

   // Register and counter state.
   prw_ivl_t  reset_interval_count_q;
   prw_ivl_t  wut_q;
   prw_ivl_t  div_q;
   prw_ivl_t  pre_q;
   prw_ivl_t  wk_cnt_q;
   prw_ivl_t  rs_cnt_q;
   logic      prf_q;
   logic      wake_flag_q;
   logic [1:0] sts_q;
   logic [1:0] mask_q;
   logic      pend_w_q;
   logic      pend_r_q;
   prw_req_s  req_q;
   logic [31:0] prdata_q;

   // Decoded strobes and events.
   logic      wr;
   logic      rd_setup;
   logic      wr_cs1;
   logic      wr_wake;
   logic      reset_interval_count_ok;
   logic      wut_ok;
   logic      reset_interval_count_chg;
   logic      wut_chg;
   logic      restart;
   logic      run;
   logic      wclk;
   logic      wk_hit;
   logic      ev_w;
   logic      ev_r;
   logic      shallow;
   logic      deep;
   logic      fire_w;
   logic      fire_r;
   prw_ivl_t  new_ivl;

   // Address decode, used only by the error answer; the read mux decodes on its own.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `PRW_ADDR_CS1) || (a == `PRW_ADDR_WAKE) ||
               (a == `PRW_ADDR_DIV) || (a == `PRW_ADDR_STS) ||
               (a == `PRW_ADDR_MASK);
   endfunction

   // A zero wake interval still runs the wake-up counter at its full count.
   function automatic prw_ivl_t wake_lim(input prw_ivl_t v);
      wake_lim = (v == `PRW_CNT_RST) ? `PRW_IVL_RST : v;
   endfunction

   // Counter reaches its limit on this step.
   function automatic logic at_lim(input prw_ivl_t c, input prw_ivl_t l);
      at_lim = (c + 6'h01) == l;
   endfunction

   // Bus strobes; the slave never inserts wait states.
   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_cs1   = wr && (paddr == `PRW_ADDR_CS1);
   assign wr_wake  = wr && (paddr == `PRW_ADDR_WAKE);
   assign new_ivl  = pwdata[`PRW_IVL_MSB:0];
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped(paddr);

   // refuse double disable.
   // A zero is only taken while the other interval keeps something alive.
   assign reset_interval_count_ok = wr_cs1 && ((new_ivl != `PRW_CNT_RST) || (wut_q != `PRW_CNT_RST));
   assign wut_ok  = wr_wake && ((new_ivl != `PRW_CNT_RST) || (reset_interval_count_q != `PRW_CNT_RST));

   // restart on change.
   // Rewriting the same value must not disturb the running time base.
   assign reset_interval_count_chg = reset_interval_count_ok && (new_ivl != reset_interval_count_q);
   assign wut_chg  = wut_ok && (new_ivl != wut_q);
   assign restart  = reset_interval_count_chg || wut_chg;

   assign run  = !debug_freeze && !restart;
   assign wclk = run && wake_tick && (pre_q == div_q);

   assign wk_hit = wclk && at_lim(wk_cnt_q, wake_lim(wut_q));
   assign ev_w   = wk_hit && (wut_q != `PRW_CNT_RST);

   assign ev_r = wk_hit && (reset_interval_count_q != `PRW_CNT_RST) && at_lim(rs_cnt_q, reset_interval_count_q);

   // Mode classes.
   assign shallow = (cpu_mode == PM_STOP4) || (cpu_mode == PM_STOP3);
   assign deep    = (cpu_mode == PM_STOP2) || (cpu_mode == PM_STOP1);

   // vector one cycle later.
   // In shallow stop an event waits one cycle behind the clock restart.
   assign fire_w = (ev_w && !shallow) || pend_w_q;
   assign fire_r = (ev_r && !shallow) || pend_r_q;

   // own events keep registers.
   // The unit's own reset request never loops back onto presetn here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_interval_count_q <= `PRW_IVL_RST;
      end else if (reset_interval_count_ok) begin
         reset_interval_count_q <= new_ivl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wut_q <= `PRW_IVL_RST;
      end else if (wut_ok) begin
         wut_q <= new_ivl;
      end
   end

   // Wake clock divider; a divider change takes effect at once, without restarting the prescaler.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= `PRW_DIV_RST;
      end else if (wr && (paddr == `PRW_ADDR_DIV)) begin
         div_q <= new_ivl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= `PRW_CNT_RST;
      end else if (restart || wclk) begin
         pre_q <= `PRW_CNT_RST;
      end else if (run && wake_tick) begin
         pre_q <= pre_q + 6'h01;
      end
   end

   // Wake-up counter, counting divided wake clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_cnt_q <= `PRW_CNT_RST;
      end else if (restart || wk_hit) begin
         wk_cnt_q <= `PRW_CNT_RST;
      end else if (wclk) begin
         wk_cnt_q <= wk_cnt_q + 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_cnt_q <= `PRW_CNT_RST;
      end else if (restart || ev_r) begin
         rs_cnt_q <= `PRW_CNT_RST;
      end else if (wk_hit) begin
         rs_cnt_q <= rs_cnt_q + 6'h01;
      end
   end

   // Events held one cycle while the clocks restart in shallow stop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_w_q <= 1'b0;
         pend_r_q <= 1'b0;
      end else begin
         pend_w_q <= ev_w && shallow;
         pend_r_q <= ev_r && shallow;
      end
   end

   // power-on only clear.
   // Set wins over a simultaneous acknowledge so no reset is missed.
   always_ff @(posedge pclk or negedge por_resetn) begin
      if (!por_resetn) begin
         prf_q <= 1'b0;
      end else if (fire_r) begin
         prf_q <= 1'b1;
      end else if (wr_cs1 && pwdata[`PRW_ACK_BIT]) begin
         prf_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_flag_q <= 1'b0;
      end else if (fire_w) begin
         wake_flag_q <= 1'b1;
      end else if (wr_wake && pwdata[`PRW_ACK_BIT]) begin
         wake_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= '0;
      end else begin
         req_q.clk_restart     <= (ev_w || ev_r) && shallow;
         req_q.wake_vector     <= 1'b0;
         req_q.sys_reset       <= fire_r && !deep;
         req_q.por_exit        <= (fire_w || fire_r) && deep;
         req_q.por_only_status <= fire_r && deep;
      end
   end

   // The wake vector stays requested while the flag stands, so a deep
   // stop exit leaves it pending until software acknowledges the wake flag.
   always_comb begin
      req             = req_q;
      req.wake_vector = wake_flag_q;
   end

   // Sticky interrupt status; the event wins over a write-one clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= `PRW_STS_RST;
      end else begin
         if (fire_w) begin
            sts_q[`PRW_STS_WAKE] <= 1'b1;
         end else if (wr && (paddr == `PRW_ADDR_STS) && pwdata[`PRW_STS_WAKE]) begin
            sts_q[`PRW_STS_WAKE] <= 1'b0;
         end
         if (fire_r) begin
            sts_q[`PRW_STS_RESET] <= 1'b1;
         end else if (wr && (paddr == `PRW_ADDR_STS) && pwdata[`PRW_STS_RESET]) begin
            sts_q[`PRW_STS_RESET] <= 1'b0;
         end
      end
   end

   // Interrupt mask, same layout as the status register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `PRW_STS_RST;
      end else if (wr && (paddr == `PRW_ADDR_MASK)) begin
         mask_q <= pwdata[1:0];
      end
   end

   assign irq = |(sts_q & mask_q);

   // acknowledge reads zero.
   // Read data is captured in the setup cycle and shown in the access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         unique case (paddr)
            `PRW_ADDR_CS1:  prdata_q <= {24'h00_0000, prf_q, 1'b0, reset_interval_count_q};
            `PRW_ADDR_WAKE: prdata_q <= {24'h00_0000, wake_flag_q, 1'b0, wut_q};
            `PRW_ADDR_DIV:  prdata_q <= {26'h000_0000, div_q};
            `PRW_ADDR_STS:  prdata_q <= {30'h0000_0000, sts_q};
            `PRW_ADDR_MASK: prdata_q <= {30'h0000_0000, mask_q};
            default:        prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_q;

   // Checks beside the logic they guard.

   property p_prf_set;
      @(posedge pclk) disable iff (!presetn || !por_resetn)
      fire_r |=> prf_q;
   endproperty
   a_prf_set: assert property (p_prf_set)
      else $error("periodic reset flag not set after reset event");

   property p_prf_ack;
      @(posedge pclk) disable iff (!presetn || !por_resetn)
      (wr_cs1 && pwdata[`PRW_ACK_BIT] && !fire_r) |=> !prf_q;
   endproperty
   a_prf_ack: assert property (p_prf_ack)
      else $error("acknowledge did not clear periodic reset flag");

   property p_prf_hold;
      @(posedge pclk) disable iff (!presetn || !por_resetn)
      (!fire_r && !(wr_cs1 && pwdata[`PRW_ACK_BIT])) |=> prf_q == $past(prf_q);
   endproperty
   a_prf_hold: assert property (p_prf_hold)
      else $error("periodic reset flag changed without cause");

   property p_ack_reads_zero;
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && (paddr == `PRW_ADDR_CS1)) |=> !prdata[`PRW_ACK_BIT] && (prdata[7] == $past(prf_q));
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero)
      else $error("control read returned wrong flag or acknowledge bits");

   property p_double_off;
      @(posedge pclk) disable iff (!presetn)
      (wr_cs1 && (new_ivl == 6'h00) && (wut_q == 6'h00)) |=> reset_interval_count_q == $past(reset_interval_count_q);
   endproperty
   a_double_off: assert property (p_double_off)
      else $error("reset interval cleared while wake interval was zero");

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      reset_interval_count_chg |=> (pre_q == 6'h00) && (wk_cnt_q == 6'h00) && (rs_cnt_q == 6'h00);
   endproperty
   a_restart: assert property (p_restart)
      else $error("counters not restarted after interval change");

   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      (debug_freeze && !restart) |=> $stable(pre_q) && $stable(wk_cnt_q) && $stable(rs_cnt_q);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("counter moved during debug freeze");

   property p_shallow_order;
      @(posedge pclk) disable iff (!presetn)
      (ev_r && shallow) |=> req.clk_restart && !req.sys_reset ##1 req.sys_reset || req.por_exit;
   endproperty
   a_shallow_order: assert property (p_shallow_order)
      else $error("reset not preceded by clock restart in shallow stop");

   property p_deep_reset;
      @(posedge pclk) disable iff (!presetn)
      (fire_r && deep) |=> req.por_exit && req.por_only_status && !req.sys_reset;
   endproperty
   a_deep_reset: assert property (p_deep_reset)
      else $error("deep stop reset not shown as power-on exit");

   // In shallow stop the flag is set one cycle after the count wraps.
   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      ev_r |=> (rs_cnt_q == 6'h00) && (prf_q || pend_r_q);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("reset counter did not wrap on periodic reset");

endmodule // prw_ctrl

/* File: prw_sys_model.sv */
// Far-side model: a wake clock pulse source and counters of the unit's requests.
// Assumes every request field except wake_vector is a one-cycle pulse on pclk.
`timescale 1ns/100ps
module prw_sys_model (
   // Clock and power-on reset.
   input  wire logic               pclk,
   input  wire logic               sys_rstn,
   // Tick enable and unit requests.
   input  wire logic               tick_en,
   input  wire prw_pkg::prw_req_s  req,
   // Wake pulse and request counts.
   output logic                    wake_tick,
   output logic [15:0]             rst_cnt_q,
   output logic [15:0]             restart_cnt_q,
   output logic [15:0]             por_cnt_q,
   output logic [15:0]             poronly_cnt_q
);
   import prw_pkg::*;
   logic [1:0] div_q;

   // One wake pulse every four clocks stands in for the slow wake clock.
   always_ff @(posedge pclk or negedge sys_rstn) begin
      if (!sys_rstn) begin
         div_q     <= 2'h0;
         wake_tick <= 1'b0;
      end else begin
         div_q     <= div_q + 2'h1;
         wake_tick <= tick_en && (div_q == 2'h3);
      end
   end

   // Totals are kept, so a pulse that is never sampled still shows up later.
   always_ff @(posedge pclk or negedge sys_rstn) begin
      if (!sys_rstn) begin
         rst_cnt_q     <= 16'h0;
         restart_cnt_q <= 16'h0;
         por_cnt_q     <= 16'h0;
         poronly_cnt_q <= 16'h0;
      end else begin
         rst_cnt_q     <= rst_cnt_q + {15'h0, req.sys_reset};
         restart_cnt_q <= restart_cnt_q + {15'h0, req.clk_restart};
         por_cnt_q     <= por_cnt_q + {15'h0, req.por_exit};
         poronly_cnt_q <= poronly_cnt_q + {15'h0, req.por_only_status};
      end
   end
endmodule // prw_sys_model

/* File: prw_ctrl_tb.sv */
// Self-checking bench for the periodic reset unit, driven over APB.
// Assumes the far-side model supplies wake pulses and counts requests.
`timescale 1ns/100ps
`include "prw_defs.svh"
module prw_ctrl_tb;
   import prw_pkg::*;
   logic            pclk, presetn, por_resetn, psel, penable, pwrite;
   logic            pready, pslverr, irq, debug_freeze, tick_en, wake_tick, err;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [15:0]     n_rst, n_restart, n_por, n_poronly;
   prw_mode_e       cpu_mode;
   prw_req_s        req;
   int              miscompares, samples_checked;

   prw_ctrl prw_ctrl_i (.pclk(pclk), .presetn(presetn), .por_resetn(por_resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_tick(wake_tick), .cpu_mode(cpu_mode),
      .debug_freeze(debug_freeze), .req(req), .irq(irq));
   prw_sys_model prw_sys_model_i (.pclk(pclk), .sys_rstn(por_resetn), .tick_en(tick_en), .req(req),
      .wake_tick(wake_tick), .rst_cnt_q(n_rst), .restart_cnt_q(n_restart), .por_cnt_q(n_por),
      .poronly_cnt_q(n_poronly));

   // The clock runs at 40 MHz.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Print the counts and the verdict, then stop.
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compare one value against its expectation.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // One idle edge, so no strobe is driven twice in one step.
      if (i == 50) begin
         miscompares++;
         $display("ERROR %0t: bus timeout", $time);
         results();
      end
   endtask

   // Read a register and compare it.
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Bounded wait for irq or for a request count to reach a target.
   task automatic wt(input int sel, input logic [15:0] tgt);
      int i;
      for (i = 0; i < 2000; i++) begin
         @(posedge pclk);
         if ((sel == 0 && irq === 1'b1) || (sel == 1 && n_rst === tgt) ||
             (sel == 2 && n_restart === tgt) || (sel == 3 && n_por === tgt)) break;
      end
      tick_en <= 1'b0;
      if (i == 2000) begin
         miscompares++;
         $display("ERROR %0t: wait timeout", $time);
         results();
      end
   endtask

   // Main sequence; ticks are stopped while registers are examined.
   initial begin
      {presetn, por_resetn, psel, penable, pwrite, debug_freeze, tick_en} = 7'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cpu_mode = PM_RUN;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      por_resetn <= 1'b1;
      @(posedge pclk);
      rc(`PRW_ADDR_CS1, 32'h3F);
      rc(`PRW_ADDR_WAKE, 32'h3F);
      rc(`PRW_ADDR_MASK, 32'h0);
      rc(`PRW_ADDR_DIV, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `PRW_ADDR_CS1, 32'hFF);
      rc(`PRW_ADDR_CS1, 32'h3F);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h02);
      apb(1'b1, `PRW_ADDR_CS1, 32'h03);
      apb(1'b1, `PRW_ADDR_MASK, 32'h03);
      rc(`PRW_ADDR_CS1, 32'h03);
      tick_en <= 1'b1;
      wt(0, 16'h0);
      chk({31'h0, req.wake_vector}, 32'h1);
      rc(`PRW_ADDR_STS, 32'h1);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h42);
      rc(`PRW_ADDR_WAKE, 32'h02);
      chk({31'h0, req.wake_vector}, 32'h0);
      tick_en <= 1'b1;
      wt(1, 16'h1);
      rc(`PRW_ADDR_CS1, 32'h83);
      rc(`PRW_ADDR_WAKE, 32'h82);
      apb(1'b1, `PRW_ADDR_CS1, 32'h03);
      rc(`PRW_ADDR_CS1, 32'h83);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(`PRW_ADDR_CS1, 32'hBF);
      apb(1'b1, `PRW_ADDR_CS1, 32'h7F);
      rc(`PRW_ADDR_CS1, 32'h3F);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h01);
      apb(1'b1, `PRW_ADDR_CS1, 32'h00);
      rc(`PRW_ADDR_CS1, 32'h00);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h00);
      rc(`PRW_ADDR_WAKE, 32'h01);
      apb(1'b1, `PRW_ADDR_MASK, 32'h03);
      tick_en <= 1'b1;
      repeat (200) @(posedge pclk);
      chk({16'h0, n_rst}, 32'h1);
      tick_en <= 1'b0;
      apb(1'b1, `PRW_ADDR_WAKE, 32'h41);
      apb(1'b1, `PRW_ADDR_STS, 32'h03);
      debug_freeze <= 1'b1;
      tick_en <= 1'b1;
      repeat (40) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      debug_freeze <= 1'b0;
      cpu_mode <= PM_WAIT;
      wt(0, 16'h0);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h41);
      apb(1'b1, `PRW_ADDR_STS, 32'h03);
      apb(1'b1, `PRW_ADDR_CS1, 32'h01);
      cpu_mode <= PM_STOP4;
      tick_en <= 1'b1;
      wt(2, 16'h1);
      wt(0, 16'h0);
      chk({31'h0, req.wake_vector}, 32'h1);
      chk({16'h0, n_rst}, 32'h2);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h41);
      apb(1'b1, `PRW_ADDR_CS1, 32'h41);
      cpu_mode <= PM_STOP2;
      tick_en <= 1'b1;
      wt(3, 16'h1);
      repeat (3) @(posedge pclk);
      chk({16'h0, n_rst}, 32'h2);
      chk({16'h0, n_poronly}, 32'h1);
      chk({31'h0, req.wake_vector}, 32'h1);
      rc(`PRW_ADDR_CS1, 32'h81);
      apb(1'b1, `PRW_ADDR_WAKE, 32'h00);
      apb(1'b1, `PRW_ADDR_CS1, 32'h00);
      rc(`PRW_ADDR_CS1, 32'h81);
      {presetn, por_resetn} <= 2'h0;
      @(posedge pclk);
      {presetn, por_resetn} <= 2'h3;
      @(posedge pclk);
      rc(`PRW_ADDR_CS1, 32'h3F);
      results();
   end
endmodule // prw_ctrl_tb
